/* design/irb_request_enable_bank.sv */
// interrupt request latches, group zero enables and vector forwarding
// Function
// RULE1: any source request sets its request bit, held until cleared
// RULE2: with global enable set, pending enabled requests go to the core
// RULE3: with global enable clear nothing is forwarded; requests stay readable
// RULE4: bank serves all sources except watchdog and oscillator fail traps
// RULE5: group zero: timer one bit 6, timer zero bit 5, converter bit 0
// RULE6: group one: port A pin 7 bit 7, pin 6 or comparator bit 6, pins 5:0
// RULE7: group two: port C pins 3..0 in bits 3:0, bits 7:4 reserved
// RULE8: enable pair decodes 00 off, 01 low, 10 nominal, 11 high
// RULE9: enable high: timer one bit 6, timer zero bit 5, converter bit 0
// RULE10: enable low has the same layout as enable high
// RULE11: software writes zero to every reserved bit
// RULE12: sources pulse their request for exactly one clock
// RULE13: core acknowledge or software write of zero clears a request bit
// RULE14: software write of one raises the request like hardware does
// RULE15: higher level wins; within a level the lowest vector wins
// RULE16: hardware pulse beats a software clear in the same cycle
// RULE17: only a non-zero enable code is forwarded, level used to arbitrate
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module irb_request_enable_bank
  import irb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [ADDR_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [ADDR_W-1:0] hrdata,
  output logic hresp,
  input wire logic timer_one_event,
  input wire logic timer_zero_event,
  input wire logic converter_event,
  input wire logic [PORTA_W-1:0] porta_event,
  input wire logic [PORTC_W-1:0] portc_event,
  input wire logic [PORTA_W-1:0] group_one_level_high,
  input wire logic [PORTA_W-1:0] group_one_level_low,
  input wire logic [PORTC_W-1:0] group_two_level_high,
  input wire logic [PORTC_W-1:0] group_two_level_low,
  input wire logic core_ack,
  input wire logic [SRC_W-1:0] core_ack_source,
  output logic vector_request,
  output logic [SRC_W-1:0] vector_source,
  output irb_level_type vector_level,
  output logic irq
);
  irb_reg_if acc();

  // request registers, group zero enables, control and event status
  logic [DATA_W-1:0] request_group_zero_q;
  logic [DATA_W-1:0] request_group_one_q;
  logic [DATA_W-1:0] request_group_two_q;
  logic [DATA_W-1:0] group_zero_enable_high_q;
  logic [DATA_W-1:0] group_zero_enable_low_q;
  logic global_interrupt_enable_q;
  logic [DATA_W-1:0] event_status_q;
  logic [DATA_W-1:0] event_mask_q;

  logic [DATA_W-1:0] request_group_zero_d;
  logic [DATA_W-1:0] request_group_one_d;
  logic [DATA_W-1:0] request_group_two_d;
  logic [DATA_W-1:0] hw_set0;
  logic [DATA_W-1:0] hw_set1;
  logic [DATA_W-1:0] hw_set2;
  logic [SRC_CNT-1:0] ack_clear;
  logic [SRC_CNT-1:0] pending;
  logic [SRC_CNT-1:0] lvl_hi;
  logic [SRC_CNT-1:0] lvl_lo;
  logic arb_found;
  logic [SRC_W-1:0] arb_winner;
  irb_level_type arb_level;
  logic any_hw_event;
  logic [DATA_W-1:0] rdata;

  // one-hot of a source number in vector order
  function automatic logic [SRC_CNT-1:0] src_onehot(input logic [SRC_W-1:0] src);
    logic [SRC_CNT-1:0] v;
    v = '0;
    for (int i = 0; i < SRC_CNT; i++) begin
      if (src == SRC_W'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction

  // gather group zero fields into vector order
  function automatic logic [2:0] pick0(input logic [DATA_W-1:0] r);
    return {r[ADC_BIT], r[T0_BIT], r[T1_BIT]};
  endfunction

  // vector-ordered bits back to the group zero layout
  function automatic logic [DATA_W-1:0] place0(input logic [SRC_CNT-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    r[T1_BIT] = v[SRC_T1];
    r[T0_BIT] = v[SRC_T0];
    r[ADC_BIT] = v[SRC_ADC];
    return r;
  endfunction

  // the ports run pin 7 down to pin 0 in vector order, so bits reverse
  function automatic logic [PORTA_W-1:0] rev8(input logic [PORTA_W-1:0] x);
    logic [PORTA_W-1:0] r;
    r = '0;
    for (int i = 0; i < PORTA_W; i++) begin
      r[i] = x[PORTA_W-1-i];
    end
    return r;
  endfunction

  function automatic logic [PORTC_W-1:0] rev4(input logic [PORTC_W-1:0] x);
    logic [PORTC_W-1:0] r;
    r = '0;
    for (int i = 0; i < PORTC_W; i++) begin
      r[i] = x[PORTC_W-1-i];
    end
    return r;
  endfunction

  function automatic logic reg_write(input logic [IDX_W-1:0] idx);
    return acc.wr_stb && acc.addr_ok && (acc.index == idx);
  endfunction

  irb_ahb_slave u_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .acc(acc)
  );

  // hardware pulses placed at their register positions
  always_comb begin
    hw_set0 = REG_RESET;
    hw_set0[T1_BIT] = timer_one_event; // RULE5
    hw_set0[T0_BIT] = timer_zero_event;
    hw_set0[ADC_BIT] = converter_event;
    hw_set1 = porta_event & REQ1_MASK; // RULE6
    hw_set2 = {{(DATA_W-PORTC_W){1'b0}}, portc_event} & REQ2_MASK; // RULE7
  end

  // one-cycle pulses are latched, a held level simply re-sets the bit
  assign any_hw_event = |{hw_set0, hw_set1, hw_set2}; // RULE12

  // acknowledged source is cleared, watchdog and traps never appear here
  assign ack_clear = core_ack ? src_onehot(core_ack_source) : '0; // RULE13 RULE4

  // next request value: ack clear, then software write, then hardware set
  always_comb begin
    request_group_zero_d = request_group_zero_q & ~place0(ack_clear); // RULE13
    request_group_one_d = request_group_one_q &
      ~rev8(ack_clear[SRC_PA7 +: PORTA_W]);
    request_group_two_d = request_group_two_q &
      ~{{(DATA_W-PORTC_W){1'b0}}, rev4(ack_clear[SRC_PC3 +: PORTC_W])};
    if (reg_write(IDX_REQ0)) begin
      request_group_zero_d = acc.wdata & REQ0_MASK; // RULE14 RULE11
    end
    if (reg_write(IDX_REQ1)) begin
      request_group_one_d = acc.wdata & REQ1_MASK; // RULE14
    end
    if (reg_write(IDX_REQ2)) begin
      request_group_two_d = acc.wdata & REQ2_MASK; // RULE14
    end
    request_group_zero_d = request_group_zero_d | hw_set0; // RULE1 RULE16
    request_group_one_d = request_group_one_d | hw_set1; // RULE1 RULE16
    request_group_two_d = request_group_two_d | hw_set2; // RULE1 RULE16
  end

  // request latches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      request_group_zero_q <= REG_RESET;
      request_group_one_q <= REG_RESET;
      request_group_two_q <= REG_RESET;
    end else begin
      request_group_zero_q <= request_group_zero_d; // RULE1
      request_group_one_q <= request_group_one_d;
      request_group_two_q <= request_group_two_d;
    end
  end

  // group zero enable pair; reserved bits stay zero whatever is written
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_zero_enable_high_q <= REG_RESET;
      group_zero_enable_low_q <= REG_RESET;
    end else begin
      if (reg_write(IDX_EN0_HI)) begin
        group_zero_enable_high_q <= acc.wdata & EN0_MASK; // RULE9
      end
      if (reg_write(IDX_EN0_LO)) begin
        group_zero_enable_low_q <= acc.wdata & EN0_MASK; // RULE10
      end
    end
  end

  // global enable: software sets or clears, an acknowledge clears it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      global_interrupt_enable_q <= 1'b0;
    end else if (reg_write(IDX_CTRL)) begin
      global_interrupt_enable_q <= acc.wdata[GIE_BIT];
    end else if (core_ack) begin
      global_interrupt_enable_q <= 1'b0;
    end
  end

  // sources laid out in vector order for the arbiter
  assign pending = {rev4(request_group_two_q[PORTC_W-1:0]),
                    rev8(request_group_one_q), pick0(request_group_zero_q)};
  assign lvl_hi = {rev4(group_two_level_high), rev8(group_one_level_high),
                   pick0(group_zero_enable_high_q)};
  assign lvl_lo = {rev4(group_two_level_low), rev8(group_one_level_low),
                   pick0(group_zero_enable_low_q)};

  irb_arbiter #(
    .N(SRC_CNT),
    .W(SRC_W)
  ) u_arb (
    .pending(pending),
    .lvl_hi(lvl_hi),
    .lvl_lo(lvl_lo),
    .found(arb_found),
    .winner(arb_winner),
    .level(arb_level)
  );

  // vector request to the core; one cycle late so it comes from a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vector_request <= 1'b0;
      vector_source <= '0;
      vector_level <= LVL_OFF;
    end else begin
      // the acked bit is still set this cycle, so suppress a stale repeat
      vector_request <= global_interrupt_enable_q && arb_found && // RULE2 RULE3
        !core_ack;
      vector_source <= arb_winner;
      vector_level <= arb_level;
    end
  end

  // event status: set beats the clear that a read of the register causes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_status_q <= REG_RESET;
    end else begin
      if (acc.rd_stb && acc.addr_ok && (acc.index == IDX_STAT)) begin
        event_status_q <= REG_RESET;
      end
      if (any_hw_event) begin
        event_status_q[STAT_REQ_BIT] <= 1'b1;
      end
      if (core_ack) begin
        event_status_q[STAT_ACK_BIT] <= 1'b1;
      end
    end
  end

  // mask and the level interrupt line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_mask_q <= REG_RESET;
      irq <= 1'b0;
    end else begin
      if (reg_write(IDX_MASK)) begin
        event_mask_q <= acc.wdata & STAT_MASK;
      end
      irq <= |(event_status_q & event_mask_q);
    end
  end

  // read mux; polling reads work whatever the global enable says
  always_comb begin
    rdata = REG_RESET;
    if (!acc.addr_ok) begin
      rdata = REG_RESET;
    end else if (acc.index == IDX_REQ0) begin
      rdata = request_group_zero_q; // RULE3
    end else if (acc.index == IDX_EN0_HI) begin
      rdata = group_zero_enable_high_q;
    end else if (acc.index == IDX_EN0_LO) begin
      rdata = group_zero_enable_low_q;
    end else if (acc.index == IDX_REQ1) begin
      rdata = request_group_one_q;
    end else if (acc.index == IDX_REQ2) begin
      rdata = request_group_two_q;
    end else if (acc.index == IDX_CTRL) begin
      rdata = {{(DATA_W-1){1'b0}}, global_interrupt_enable_q} & CTRL_MASK;
    end else if (acc.index == IDX_STAT) begin
      rdata = event_status_q;
    end else if (acc.index == IDX_MASK) begin
      rdata = event_mask_q;
    end
  end

  assign acc.rdata = rdata;

  // hsize is not checked: only whole-word transfers are expected
  logic unused_size;
  assign unused_size = ^hsize;
endmodule

/* pkg/irb_pkg.sv */
// constants and types shared by the interrupt request and enable bank
package irb_pkg;
  localparam int DATA_W = 8;
  localparam int IDX_W = 12;
  localparam int ADDR_W = 32;
  localparam int IDX_LSB = 2;
  // word index of each register; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REQ0 = 12'hfc0;
  localparam logic [IDX_W-1:0] IDX_EN0_HI = 12'hfc1;
  localparam logic [IDX_W-1:0] IDX_EN0_LO = 12'hfc2;
  localparam logic [IDX_W-1:0] IDX_REQ1 = 12'hfc3;
  localparam logic [IDX_W-1:0] IDX_REQ2 = 12'hfc6;
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'hfcf;
  localparam logic [IDX_W-1:0] IDX_STAT = 12'hfd0;
  localparam logic [IDX_W-1:0] IDX_MASK = 12'hfd1;
  // implemented bits per register, the rest read zero and ignore writes
  localparam logic [DATA_W-1:0] REQ0_MASK = 8'h61;
  localparam logic [DATA_W-1:0] EN0_MASK = 8'h61;
  localparam logic [DATA_W-1:0] REQ1_MASK = 8'hff;
  localparam logic [DATA_W-1:0] REQ2_MASK = 8'h0f;
  localparam logic [DATA_W-1:0] CTRL_MASK = 8'h01;
  localparam logic [DATA_W-1:0] STAT_MASK = 8'h03;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // field positions
  localparam int T1_BIT = 6;
  localparam int T0_BIT = 5;
  localparam int ADC_BIT = 0;
  localparam int GIE_BIT = 0;
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int PORTA_W = 8;
  localparam int PORTC_W = 4;
  // sources in fixed vector order, index 0 has the lowest vector
  localparam int SRC_CNT = 15;
  localparam int SRC_W = 4;
  localparam int SRC_T1 = 0;
  localparam int SRC_T0 = 1;
  localparam int SRC_ADC = 2;
  localparam int SRC_PA7 = 3;
  localparam int SRC_PC3 = 11;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {
    LVL_OFF = 2'b00, LVL_LOW = 2'b01, LVL_NOM = 2'b10, LVL_HIGH = 2'b11
  } irb_level_type;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00, BUS_WRITE = 2'b01, BUS_RD_WAIT = 2'b10, BUS_RD_DONE = 2'b11
  } irb_bus_state_type;
endpackage

/* pkg/irb_reg_if.sv */
// register access carrier between the bus slave and the register bank
`timescale 1ns/1ps
interface irb_reg_if;
  import irb_pkg::*;
  logic wr_stb;
  logic rd_stb;
  logic addr_ok;
  logic [IDX_W-1:0] index;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport bus (output wr_stb, output rd_stb, output addr_ok, output index,
    output wdata, input rdata);
  modport regs (input wr_stb, input rd_stb, input addr_ok, input index,
    input wdata, output rdata);
endinterface

/* design/irb_ahb_slave.sv */
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module irb_ahb_slave
  import irb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [ADDR_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [ADDR_W-1:0] hrdata,
  output logic hresp,
  irb_reg_if.bus acc
);
  irb_bus_state_type state_q;
  logic [IDX_W-1:0] index_q;
  logic addr_ok_q;
  logic take;

  // a transfer is taken only when the previous data phase has finished
  assign take = hsel && hready && htrans[1];

  // data phase sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
    end else begin
      case (state_q)
        BUS_RD_WAIT: state_q <= BUS_RD_DONE;
        default: begin
          if (take) begin
            state_q <= hwrite ? BUS_WRITE : BUS_RD_WAIT;
          end else begin
            state_q <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  // address phase capture; misaligned or out-of-window reads as unmapped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= '0;
      addr_ok_q <= 1'b0;
    end else if (take) begin
      index_q <= haddr[IDX_LSB +: IDX_W];
      addr_ok_q <= (haddr[ADDR_W-1:IDX_LSB+IDX_W] == '0) && (haddr[IDX_LSB-1:0] == '0);
    end
  end

  // read data is registered so hrdata comes from a flop; costs one wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
      if (take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (state_q == BUS_RD_WAIT) begin
        hreadyout <= 1'b1;
        hrdata <= {{(ADDR_W-DATA_W){1'b0}}, acc.rdata};
      end
    end
  end

  assign acc.wr_stb = (state_q == BUS_WRITE);
  assign acc.rd_stb = (state_q == BUS_RD_WAIT);
  assign acc.addr_ok = addr_ok_q;
  assign acc.index = index_q;
  assign acc.wdata = hwdata[DATA_W-1:0];
endmodule

/* design/irb_arbiter.sv */
// level-then-vector priority pick among pending, enabled sources
`timescale 1ns/1ps
module irb_arbiter
  import irb_pkg::*;
#(
  parameter int N = SRC_CNT,
  parameter int W = SRC_W
) (
  input wire logic [N-1:0] pending,
  input wire logic [N-1:0] lvl_hi,
  input wire logic [N-1:0] lvl_lo,
  output logic found,
  output logic [W-1:0] winner,
  output irb_level_type level
);
  // walk from the highest vector down; >= lets a lower vector win a tie
  always_comb begin
    found = 1'b0;
    winner = '0;
    level = LVL_OFF;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i] && ({lvl_hi[i], lvl_lo[i]} != LVL_OFF) && // RULE17
          ({lvl_hi[i], lvl_lo[i]} >= level)) begin // RULE15
        found = 1'b1;
        winner = W'(i);
        level = irb_level_type'({lvl_hi[i], lvl_lo[i]}); // RULE8
      end
    end
  end
endmodule

/* test/irb_props.sv */
// port-level checks for the interrupt request and enable bank
`timescale 1ns/1ps
module irb_props
  import irb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [ADDR_W-1:0] hrdata,
  input wire logic hresp,
  input wire logic core_ack,
  input wire logic vector_request,
  input wire logic [SRC_W-1:0] vector_source,
  input wire irb_level_type vector_level,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic taken;
  // a transfer is taken when selected, ready and htrans is non-sequential or sequential
  assign taken = hsel && hready && htrans[1];
  // bus timing
  a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait is not one cycle");
  a_resp_always_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  // read data may only move on the edge that ends a read wait
  a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside a read");
  // vector link
  a_level_nonzero: assert property (vector_request |-> vector_level != LVL_OFF)
    else $error("forwarded vector with disabled level");
  a_source_in_range: assert property (vector_request |-> vector_source < SRC_CNT)
    else $error("vector source out of range");
  a_ack_drops_vec: assert property (core_ack |=> !vector_request)
    else $error("vector still requested after acknowledge");
  c_read: cover property (taken && !hwrite);
  c_vector: cover property ($rose(vector_request));
  c_irq: cover property ($rose(irq));
endmodule
bind irb_request_enable_bank irb_props u_props (.clk_sys, .rst_n, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .core_ack, .vector_request, .vector_source,
  .vector_level, .irq);

/* test/irb_core_model.sv */
// core side model: acknowledges the forwarded vector after a set delay
`timescale 1ns/1ps
module irb_core_model
  import irb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic vector_request,
  input wire logic [SRC_W-1:0] vector_source,
  output logic core_ack,
  output logic [SRC_W-1:0] core_ack_source
);
  logic [3:0] wait_q;
  // one-cycle acknowledge; source toggles when idle so a stale value never looks valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      core_ack <= 1'b0;
      core_ack_source <= 4'h0;
    end else begin
      core_ack <= 1'b0;
      core_ack_source <= ~core_ack_source;
      wait_q <= 4'h0;
      if (ack_en && vector_request && !core_ack) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == ack_delay) begin
          core_ack <= 1'b1;
          core_ack_source <= vector_source;
        end
      end
    end
  end
endmodule

/* test/irb_request_enable_bank_tb_top.sv */
// self-checking bench for the interrupt request and enable bank
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module irb_request_enable_bank_tb_top
  import irb_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic converter_event = 1'b0;
  logic timer_one_event = 1'b0;
  logic timer_zero_event = 1'b0;
  logic ack_en = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [ADDR_W-1:0] haddr = 32'h00000000;
  logic [ADDR_W-1:0] hwdata = 32'h00000000;
  logic [7:0] porta_event = 8'h00;
  logic [7:0] group_one_level_high = 8'h00;
  logic [7:0] group_one_level_low = 8'h00;
  logic [3:0] portc_event = 4'h0;
  logic [3:0] group_two_level_high = 4'h0;
  logic [3:0] group_two_level_low = 4'h0;
  logic [3:0] ack_delay = 4'h0;
  logic hready, hreadyout, hresp, core_ack, vector_request, irq;
  logic [ADDR_W-1:0] hrdata;
  logic [SRC_W-1:0] core_ack_source, vector_source;
  irb_level_type vector_level;
  logic [7:0] rd, r0, r1, r2, eh, el, g1h, g1l, g2h, g2l;
  logic [6:0] exp_w;
  logic [14:0] pend;
  logic [31:0] seed = 32'h000149f6;
  int err_count = 0;
  int cmp_count = 0;
  logic [IDX_W-1:0] tbl [5] = '{IDX_REQ0, IDX_EN0_HI, IDX_EN0_LO, IDX_REQ1, IDX_REQ2};
  logic [7:0] msk [5] = '{REQ0_MASK, EN0_MASK, EN0_MASK, REQ1_MASK, REQ2_MASK};
  // the single slave's ready is the bus ready
  assign hready = hreadyout;
  always #12.5 clk_sys = ~clk_sys;
  irb_request_enable_bank dut (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .timer_one_event, .timer_zero_event,
    .converter_event, .porta_event, .portc_event, .group_one_level_high,
    .group_one_level_low, .group_two_level_high, .group_two_level_low, .core_ack,
    .core_ack_source, .vector_request, .vector_source, .vector_level, .irq);
  irb_core_model core (.clk_sys, .rst_n, .ack_en, .ack_delay, .vector_request,
    .vector_source, .core_ack, .core_ack_source);
  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // lfsr, eight shifts per byte so successive values are not simple shifts
  function automatic logic [7:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
    return {18'h00000, i, 2'h0};
  endfunction
  // register layouts into vector order, lowest vector first
  function automatic logic [14:0] to_src(input logic [7:0] a, b, c);
    logic [14:0] s;
    s[0] = a[6];
    s[1] = a[5];
    s[2] = a[0];
    for (int k = 0; k < 8; k++) s[3+k] = b[7-k];
    for (int k = 0; k < 4; k++) s[11+k] = c[3-k];
    return s;
  endfunction
  // winner as {found, level, source}: higher level first, then lowest vector
  function automatic logic [6:0] pick(input logic [14:0] p, h, l);
    logic [6:0] r;
    r = 7'h00;
    for (int i = SRC_CNT - 1; i >= 0; i--)
      if (p[i] && {h[i], l[i]} != 2'h0 && {h[i], l[i]} >= r[5:4]) r = {1'b1, h[i], l[i], 4'(i)};
    return r;
  endfunction
  // ready sampled at rising edges; a bus that never answers ends the run
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_count++;
      results();
    end
  endtask
  // single ahb-lite transfer; f pulses the converter source during the data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd, input logic f);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    converter_event <= f;
    wait_ready();
    converter_event <= 1'b0;
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
    bus(1'b1, ba(i), d, 1'b0);
  endtask
  task automatic rdr(input logic [IDX_W-1:0] i);
    bus(1'b0, ba(i), 8'h00, 1'b0);
  endtask
  // every source pulses for exactly one clock
  task automatic pulse(input logic [7:0] p0, p1, p2);
    @(posedge clk_sys);
    {timer_one_event, timer_zero_event, converter_event, porta_event, portc_event} <= {p0[6], p0[5], p0[0], p1, p2[3:0]};
    @(posedge clk_sys);
    {timer_one_event, timer_zero_event, converter_event, porta_event, portc_event} <= 15'h0000;
  endtask
  task automatic wait_vec(input logic lvl, input int lim);
    int n = 0;
    while (vector_request !== lvl && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset value, implemented bits, set by one and clear by zero
    for (int i = 0; i < 5; i++) begin
      rdr(tbl[i]);
      `CHK(rd, 8'h00)
      wr(tbl[i], msk[i]);
      rdr(tbl[i]);
      `CHK(rd, msk[i])
      wr(tbl[i], 8'h00);
      rdr(tbl[i]);
      `CHK(rd, 8'h00)
    end
    // unmapped address reads zero
    bus(1'b1, 32'h80003f00, 8'hff, 1'b0);
    bus(1'b0, 32'h80003f00, 8'h00, 1'b0);
    `CHK(rd, 8'h00)
    // random hardware pulses accumulate in their request bits
    pend = 15'h0000;
    repeat (4) begin
      r0 = rnd();
      r1 = rnd();
      r2 = rnd();
      pulse(r0, r1, r2);
      pend = pend | to_src(r0, r1, r2);
    end
    rdr(IDX_REQ0);
    r0 = rd;
    rdr(IDX_REQ1);
    r1 = rd;
    rdr(IDX_REQ2);
    `CHK({r0 & ~REQ0_MASK, rd & ~REQ2_MASK, to_src(r0, r1, rd)}, {16'h0000, pend})
    // a pulse wins against a software clear in the same cycle
    wr(IDX_REQ1, 8'h00);
    wr(IDX_REQ2, 8'h00);
    bus(1'b1, ba(IDX_REQ0), 8'h00, 1'b1);
    rdr(IDX_REQ0);
    `CHK(rd, 8'h01)
    // arbitration over random levels, core answering promptly or slowly
    ack_en <= 1'b1;
    repeat (16) begin
      wr(IDX_CTRL, 8'h00);
      r0 = rnd() & REQ0_MASK;
      r1 = rnd();
      r2 = rnd() & REQ2_MASK;
      eh = rnd() & EN0_MASK;
      el = rnd() & EN0_MASK;
      g1h = rnd();
      g1l = rnd();
      g2h = rnd();
      g2l = rnd();
      {group_one_level_high, group_one_level_low} <= {g1h, g1l};
      {group_two_level_high, group_two_level_low} <= {g2h[3:0], g2l[3:0]};
      ack_delay <= {1'b0, g2h[7:5]};
      wr(IDX_EN0_HI, eh);
      wr(IDX_EN0_LO, el);
      wr(IDX_REQ0, r0);
      wr(IDX_REQ1, r1);
      wr(IDX_REQ2, r2);
      pend = to_src(r0, r1, r2);
      exp_w = pick(pend, to_src(eh, g1h, g2h), to_src(el, g1l, g2l));
      repeat (3) @(negedge clk_sys);
      `CHK(vector_request, 1'b0)
      wr(IDX_CTRL, 8'h01);
      wait_vec(1'b1, 6);
      `CHK(vector_request, exp_w[6])
      if (exp_w[6]) begin
        `CHK({vector_level, vector_source}, exp_w[5:0])
        wait_vec(1'b0, 20);
        `CHK(vector_request, 1'b0)
        pend[exp_w[3:0]] = 1'b0;
        rdr(IDX_REQ0);
        r0 = rd;
        rdr(IDX_REQ1);
        r1 = rd;
        rdr(IDX_REQ2);
        `CHK(to_src(r0, r1, rd), pend)
      end
    end
    // interrupt output: raised when unmasked, cleared by reading status, masked off
    ack_en <= 1'b0;
    wr(IDX_CTRL, 8'h00);
    wr(IDX_MASK, 8'h01);
    rdr(IDX_STAT);
    pulse(8'h01, 8'h00, 8'h00);
    repeat (3) @(negedge clk_sys);
    `CHK(irq, 1'b1)
    rdr(IDX_STAT);
    `CHK(rd, 8'h01)
    repeat (3) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    wr(IDX_MASK, 8'h02);
    pulse(8'h01, 8'h00, 8'h00);
    repeat (3) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    results();
  end
endmodule
